/* File: mos_params.svh */
// Constants for the measurement-mode output selector: offsets, fields, resets and widths
`ifndef MOS_PARAMS_SVH
`define MOS_PARAMS_SVH

// Widths
`define MOS_DW 16
`define MOS_AW 8
`define MOS_CW 16
`define MOS_ACC_W 48

// Unscaled full scale, 100.0 in 8.8 fixed point
`define MOS_US_FULL 16'h6400

// Register offsets (word index on the plain register port)
`define MOS_REG_AOUT1 8'h00
`define MOS_REG_AOUT2 8'h01
`define MOS_REG_FALLBACK 8'h02
`define MOS_REG_US2_MODE 8'h03
`define MOS_REG_NAT_ADDR 8'h04
`define MOS_REG_NAT_BAUD 8'h05
`define MOS_REG_SEC_PROTO 8'h06
`define MOS_REG_MB_ADDR 8'h07
`define MOS_REG_MB_BAUD 8'h08
`define MOS_REG_MB_PARITY 8'h09
`define MOS_REG_STATUS 8'h0a
`define MOS_REG_COEF_BASE 8'h10
`define MOS_REG_MOIST_BASE 8'h20
`define MOS_REG_FUS_BASE 8'h28
`define MOS_REG_AUS_BASE 8'h2c

// Output selection field positions
`define MOS_SEL_QTY_LSB 0
`define MOS_SEL_HAS_MODE 2
`define MOS_SEL_MODE_LSB 3

// Reset values
`define MOS_RST_AOUT1 5'h00
`define MOS_RST_AOUT2 5'h01
`define MOS_RST_FALLBACK 2'h0
`define MOS_RST_US2_MODE 2'h1
`define MOS_RST_NAT_ADDR 8'h10
`define MOS_RST_NAT_BAUD 3'h3
`define MOS_RST_SEC_PROTO 1'h1
`define MOS_RST_MB_ADDR 8'h01
`define MOS_RST_MB_BAUD 3'h3
`define MOS_RST_MB_PARITY 2'h0

// Modbus address limits
`define MOS_MB_ADDR_MIN 8'h01
`define MOS_MB_ADDR_MAX 8'hf7

// Coefficient memory layout: four sets of four coefficients
`define MOS_COEF_DEPTH 16
`define MOS_LEGACY_SET 2'h3
`define MOS_ENG_LAST_PHASE 3'h4

`endif

/* File: mos_pkg.sv */
// Types shared by the measurement-mode output selector
package mos_pkg;

   // Measurement modes; code 3 is not a mode
   typedef enum logic [1:0] {
      MODE_F,
      MODE_V,
      MODE_E
   } mode_t;

   // Output quantities
   typedef enum logic [1:0] {
      QTY_FILT_US,
      QTY_AVG_US,
      QTY_FILT_MOIST,
      QTY_AVG_MOIST
   } quantity_t;

   // Serial protocol of a request
   typedef enum logic {
      PROTO_NATIVE,
      PROTO_MODBUS
   } proto_t;

   // Secondary protocol parity and stop bits
   typedef enum logic [1:0] {
      PAR_NONE_1STOP,
      PAR_NONE_2STOP,
      PAR_ODD,
      PAR_EVEN
   } parity_t;

   // Baud choices, 2400 up to 115200
   typedef enum logic [2:0] {
      BAUD_2400,
      BAUD_4800,
      BAUD_9600,
      BAUD_19200,
      BAUD_38400,
      BAUD_57600,
      BAUD_115200
   } baud_t;

endpackage

/* File: coef_if.sv */
// Coefficient memory port bundle between the selector and its memory
`timescale 1ns/10ps
`default_nettype none
`include "mos_params.svh"

interface coef_if;
   logic wr_en;
   logic [3:0] wr_addr;
   logic [`MOS_CW-1:0] wr_data;
   logic [3:0] rd_addr;
   logic [`MOS_CW-1:0] rd_data;

   // Selector side
   modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   // Memory side
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

/* File: coef_mem.sv */
// Calibration coefficient memory with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "mos_params.svh"

module coef_mem (
   // Clock and control
   input wire logic clk_i,
   input wire logic ce_i,
   // Memory port
   coef_if.mem port
);

   logic [`MOS_CW-1:0] store [`MOS_COEF_DEPTH];

   // Write port
   always_ff @(posedge clk_i) begin
      if (ce_i && port.wr_en) begin
         store[port.wr_addr] <= port.wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         port.rd_data <= store[port.rd_addr];
      end
   end

endmodule

`default_nettype wire

/* File: mode_output_selector.sv */
// Measurement-mode output selection, calibration and serial protocol configuration
`timescale 1ns/10ps
`default_nettype none
`include "mos_params.svh"

//Contract
// R01: Unscaled computed in all modes continuously
// R02: Unscaled scaled 0 to 100 per mode
// R03: Analogue output picks quantity and mode
// R04: Serial request may name mode and quantity
// R05: Missing mode uses fallback mode setting
// R06: Mode-less moisture uses legacy coefficients if nonzero
// R07: All-zero legacy uses fallback mode moisture
// R08: Four coefficients held per mode
// R09: Second unscaled output for alternate mode
// R10: Two analogue outputs configured independently
// R11: Native protocol default, Modbus optional
// R12: One protocol message processed at once
// R13: Modbus has own address, baud, parity
// R14: Modbus accepted only when enabled and matching
// R15: Modbus frames ignored when secondary disabled
module mode_output_selector (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Register port
   input wire logic [`MOS_AW-1:0] reg_addr_i,
   input wire logic [`MOS_DW-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [`MOS_DW-1:0] reg_rdata_o,
   // Per-mode unscaled inputs from the filter chain, 8.8 fixed point
   input wire logic [2:0][`MOS_DW-1:0] filt_us_i,
   input wire logic [2:0][`MOS_DW-1:0] avg_us_i,
   // Serial request from the protocol decoders
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire mos_pkg::proto_t req_proto_i,
   input wire logic [7:0] req_dev_addr_i,
   input wire mos_pkg::quantity_t req_qty_i,
   input wire logic req_has_mode_i,
   input wire mos_pkg::mode_t req_mode_i,
   // Serial answer
   output logic resp_valid_o,
   output mos_pkg::proto_t resp_proto_o,
   output logic [`MOS_DW-1:0] resp_data_o,
   // Analogue loop values and compatibility output
   output logic [`MOS_DW-1:0] aout1_o,
   output logic [`MOS_DW-1:0] aout2_o,
   output logic [`MOS_DW-1:0] us2_o,
   // Line settings for the serial front end
   output logic [7:0] nat_addr_o,
   output mos_pkg::baud_t nat_baud_o,
   output logic sec_enable_o,
   output logic [7:0] mb_addr_o,
   output mos_pkg::baud_t mb_baud_o,
   output mos_pkg::parity_t mb_parity_o
);

   coef_if cif ();

   logic [4:0] aout1_sel;
   logic [4:0] aout2_sel;
   mos_pkg::mode_t fallback;
   mos_pkg::mode_t us2_mode;
   logic [3:0] legacy_nz;
   logic [2:0][`MOS_DW-1:0] filt_us;
   logic [2:0][`MOS_DW-1:0] avg_us;
   logic [3:0][1:0][`MOS_DW-1:0] moist;
   logic [1:0] eng_set;
   logic eng_q;
   logic [2:0] eng_phase;
   logic [`MOS_DW-1:0] eng_u;
   logic [31:0] eng_u2;
   logic signed [`MOS_ACC_W-1:0] acc;
   logic signed [`MOS_ACC_W-1:0] next_acc;
   logic coef_hit;
   logic mb_hit;

   // Coefficient memory
   coef_mem mem_u (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .port(cif.mem)
   );

   // Any mode code outside the three modes falls back to mode F
   function automatic logic [1:0] legal_mode(input logic [1:0] m);
      legal_mode = (m == 2'h3) ? 2'h0 : m;
   endfunction

   // Clamp an unscaled value to the 0..100 range
   function automatic logic [`MOS_DW-1:0] clamp_us(input logic [`MOS_DW-1:0] v);
      clamp_us = (v > `MOS_US_FULL) ? `MOS_US_FULL : v;
   endfunction

   // Value of a quantity, resolving a missing mode
   function automatic logic [`MOS_DW-1:0] pick(input logic [1:0] qty, input logic has_mode,
                                               input logic [1:0] mode);
      logic [1:0] m;
      m = legal_mode(has_mode ? mode : fallback);
      pick = '0;
      unique case (qty)
         2'h0: pick = filt_us[m];
         2'h1: pick = avg_us[m];
         default: begin
            if (!has_mode && (legacy_nz != 4'h0)) begin
               pick = moist[`MOS_LEGACY_SET][qty[0]];
            end else begin
               pick = moist[m][qty[0]];
            end
         end
      endcase
   endfunction

   // R01 every mode sampled
   // R02 scale limited to 100
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         filt_us <= '0;
         avg_us <= '0;
      end else if (ce_i) begin
         for (int i = 0; i < 3; i++) begin
            filt_us[i] <= clamp_us(filt_us_i[i]);
            avg_us[i] <= clamp_us(avg_us_i[i]);
         end
      end
   end

   assign coef_hit = reg_wr_i && (reg_addr_i[7:4] == 4'(`MOS_REG_COEF_BASE >> 4));

   // Coefficient writes and engine reads
   assign cif.wr_en = coef_hit;
   assign cif.wr_addr = reg_addr_i[3:0];
   assign cif.wr_data = reg_wdata_i;
   assign cif.rd_addr = {eng_set, eng_phase[1:0]};

   // R06 track legacy coefficients that are non-zero
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         legacy_nz <= 4'h0;
      end else if (ce_i && coef_hit && reg_addr_i[3:2] == `MOS_LEGACY_SET) begin
         legacy_nz[reg_addr_i[1:0]] <= (reg_wdata_i != '0);
      end
   end

   // Unscaled input to the engine; the legacy set follows the fallback mode
   always_comb begin
      eng_u = '0;
      if (eng_set == `MOS_LEGACY_SET) begin
         eng_u = eng_q ? avg_us[legal_mode(fallback)] : filt_us[legal_mode(fallback)];
      end else begin
         eng_u = eng_q ? avg_us[eng_set] : filt_us[eng_set];
      end
      eng_u2 = eng_u * eng_u;
   end

   // Fold in the term of the coefficient that arrived this phase; A starts the sum, B and C are added, D is subtracted
   always_comb begin
      logic signed [`MOS_ACC_W-1:0] c;
      c = `MOS_ACC_W'(signed'(cif.rd_data));
      next_acc = acc;
      unique case (eng_phase)
         3'h1: next_acc = (c * signed'({16'h0, eng_u2})) >>> 16;
         3'h2: next_acc = acc + ((c * signed'({32'h0, eng_u})) >>> 8);
         3'h3: next_acc = acc + c;
         3'h4: next_acc = acc - c;
         default: next_acc = acc;
      endcase
   end

   // R08 one four-coefficient set per mode plus the legacy set, walked in turn
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         eng_phase <= 3'h0;
         eng_set <= 2'h0;
         eng_q <= 1'b0;
         acc <= '0;
      end else if (ce_i) begin
         acc <= next_acc;
         if (eng_phase == `MOS_ENG_LAST_PHASE) begin
            eng_phase <= 3'h0;
            eng_q <= ~eng_q;
            if (eng_q) begin
               eng_set <= eng_set + 2'h1;
            end
         end else begin
            eng_phase <= eng_phase + 3'h1;
         end
      end
   end

   // Moisture results, A*u^2 + B*u + C - D in 8.8 fixed point
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         moist <= '0;
      end else if (ce_i && eng_phase == `MOS_ENG_LAST_PHASE) begin
         moist[eng_set][eng_q] <= next_acc[`MOS_DW-1:0];
      end
   end

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         aout1_sel <= `MOS_RST_AOUT1;
         aout2_sel <= `MOS_RST_AOUT2;
         fallback <= mos_pkg::mode_t'(`MOS_RST_FALLBACK);
         us2_mode <= mos_pkg::mode_t'(`MOS_RST_US2_MODE);
         nat_addr_o <= `MOS_RST_NAT_ADDR;
         nat_baud_o <= mos_pkg::baud_t'(`MOS_RST_NAT_BAUD);
         sec_enable_o <= `MOS_RST_SEC_PROTO;
         mb_addr_o <= `MOS_RST_MB_ADDR;
         mb_baud_o <= mos_pkg::baud_t'(`MOS_RST_MB_BAUD);
         mb_parity_o <= mos_pkg::parity_t'(`MOS_RST_MB_PARITY);
      end else if (ce_i && reg_wr_i) begin
         unique case (reg_addr_i)
            // R10 two independent output selections
            `MOS_REG_AOUT1: aout1_sel <= reg_wdata_i[4:0];
            `MOS_REG_AOUT2: aout2_sel <= reg_wdata_i[4:0];
            `MOS_REG_FALLBACK: fallback <= mos_pkg::mode_t'(legal_mode(reg_wdata_i[1:0]));
            `MOS_REG_US2_MODE: us2_mode <= mos_pkg::mode_t'(legal_mode(reg_wdata_i[1:0]));
            `MOS_REG_NAT_ADDR: nat_addr_o <= reg_wdata_i[7:0];
            `MOS_REG_NAT_BAUD: begin
               if (reg_wdata_i[2:0] <= 3'h6) begin
                  nat_baud_o <= mos_pkg::baud_t'(reg_wdata_i[2:0]);
               end
            end
            // R11 secondary protocol switch
            `MOS_REG_SEC_PROTO: sec_enable_o <= reg_wdata_i[0];
            // R13 separate Modbus line settings, address kept in 1..247
            `MOS_REG_MB_ADDR: begin
               if (reg_wdata_i[7:0] >= `MOS_MB_ADDR_MIN && reg_wdata_i[7:0] <= `MOS_MB_ADDR_MAX
                   && reg_wdata_i[15:8] == 8'h00) begin
                  mb_addr_o <= reg_wdata_i[7:0];
               end
            end
            `MOS_REG_MB_BAUD: begin
               if (reg_wdata_i[2:0] <= 3'h6) begin
                  mb_baud_o <= mos_pkg::baud_t'(reg_wdata_i[2:0]);
               end
            end
            `MOS_REG_MB_PARITY: mb_parity_o <= mos_pkg::parity_t'(reg_wdata_i[1:0]);
            default: ;
         endcase
      end
   end

   // Register reads, data in the following cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= '0;
      end else if (ce_i) begin
         reg_rdata_o <= '0;
         if (reg_rd_i) begin
            unique casez (reg_addr_i)
               `MOS_REG_AOUT1: reg_rdata_o <= {11'h0, aout1_sel};
               `MOS_REG_AOUT2: reg_rdata_o <= {11'h0, aout2_sel};
               `MOS_REG_FALLBACK: reg_rdata_o <= {14'h0, fallback};
               `MOS_REG_US2_MODE: reg_rdata_o <= {14'h0, us2_mode};
               `MOS_REG_NAT_ADDR: reg_rdata_o <= {8'h0, nat_addr_o};
               `MOS_REG_NAT_BAUD: reg_rdata_o <= {13'h0, nat_baud_o};
               `MOS_REG_SEC_PROTO: reg_rdata_o <= {15'h0, sec_enable_o};
               `MOS_REG_MB_ADDR: reg_rdata_o <= {8'h0, mb_addr_o};
               `MOS_REG_MB_BAUD: reg_rdata_o <= {13'h0, mb_baud_o};
               `MOS_REG_MB_PARITY: reg_rdata_o <= {14'h0, mb_parity_o};
               `MOS_REG_STATUS: reg_rdata_o <= {12'h0, legacy_nz};
               8'b0010_0???: reg_rdata_o <= moist[reg_addr_i[2:1]][reg_addr_i[0]];
               8'b0010_10??: reg_rdata_o <= filt_us[legal_mode(reg_addr_i[1:0])];
               8'b0010_11??: reg_rdata_o <= avg_us[legal_mode(reg_addr_i[1:0])];
               default: reg_rdata_o <= '0;
            endcase
         end
      end
   end

   // R03 analogue outputs from their selections
   // R05 missing mode resolved by fallback
   // R07 legacy all zero uses fallback set
   // R09 compatibility unscaled in alternate mode
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         aout1_o <= '0;
         aout2_o <= '0;
         us2_o <= '0;
      end else if (ce_i) begin
         aout1_o <= pick(aout1_sel[1:0], aout1_sel[`MOS_SEL_HAS_MODE], aout1_sel[4:3]);
         aout2_o <= pick(aout2_sel[1:0], aout2_sel[`MOS_SEL_HAS_MODE], aout2_sel[4:3]);
         us2_o <= filt_us[us2_mode];
      end
   end

   // R14 Modbus only when enabled and addressed
   // R15 Modbus ignored when disabled
   assign mb_hit = sec_enable_o && (req_dev_addr_i == mb_addr_o);

   // R12 one message in flight, ready drops while answering
   assign req_ready_o = ~resp_valid_o;

   // R04 serial answer for the named quantity and mode
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         resp_valid_o <= 1'b0;
         resp_proto_o <= mos_pkg::PROTO_NATIVE;
         resp_data_o <= '0;
      end else if (ce_i) begin
         resp_valid_o <= 1'b0;
         if (req_valid_i && req_ready_o) begin
            if (req_proto_i == mos_pkg::PROTO_NATIVE || mb_hit) begin
               resp_valid_o <= 1'b1;
               resp_proto_o <= req_proto_i;
               resp_data_o <= pick(req_qty_i, req_has_mode_i, req_mode_i);
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: mos_props.sv */
// Port checker for the measurement-mode output selector
`timescale 1ns/10ps
`default_nettype none
`include "mos_params.svh"
module mos_props (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Register read port
   input wire logic reg_rd_i,
   input wire logic [`MOS_DW-1:0] reg_rdata_o,
   // Serial request and answer
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire mos_pkg::proto_t req_proto_i,
   input wire logic [7:0] req_dev_addr_i,
   input wire logic resp_valid_o,
   input wire mos_pkg::proto_t resp_proto_o,
   // Settings and compatibility output
   input wire logic [`MOS_DW-1:0] us2_o,
   input wire logic sec_enable_o,
   input wire logic [7:0] mb_addr_o,
   input wire mos_pkg::baud_t mb_baud_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic take;
   logic mb_hit;
   // Accepted request and a frame meant for this device
   assign take = req_valid_i && req_ready_o && ce_i;
   assign mb_hit = sec_enable_o && req_dev_addr_i == mb_addr_o;
   a_ready_when_idle: assert property (req_ready_o == !resp_valid_o)
      else $error("ready is not the inverse of answer valid");
   a_resp_one_pulse: assert property (resp_valid_o && ce_i |=> !resp_valid_o)
      else $error("answer valid longer than one cycle");
   a_native_answered: assert property (take && req_proto_i == mos_pkg::PROTO_NATIVE
      |=> resp_valid_o && resp_proto_o == mos_pkg::PROTO_NATIVE)
      else $error("native request not answered next cycle");
   a_modbus_answered: assert property (take && req_proto_i == mos_pkg::PROTO_MODBUS
      && mb_hit |=> resp_valid_o && resp_proto_o == mos_pkg::PROTO_MODBUS)
      else $error("matching secondary frame not answered");
   a_modbus_ignored: assert property (take && req_proto_i == mos_pkg::PROTO_MODBUS
      && !mb_hit |=> !resp_valid_o)
      else $error("secondary frame answered while off or not addressed");
   a_no_spurious: assert property (ce_i && !(req_valid_i && req_ready_o) |=> !resp_valid_o)
      else $error("answer without a request");
   a_read_window: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 16'h0000)
      else $error("read data outside the read answer cycle");
   a_mb_addr_range: assert property (mb_addr_o >= 8'h01 && mb_addr_o <= 8'hf7)
      else $error("secondary address outside 1 to 247");
   a_mb_baud_legal: assert property (mb_baud_o <= mos_pkg::BAUD_115200)
      else $error("secondary baud code out of range");
   a_us2_scale: assert property (us2_o <= `MOS_US_FULL)
      else $error("second unscaled above full scale");
endmodule
bind mode_output_selector mos_props u_props (.clk_i, .srst_i, .ce_i, .reg_rd_i, .reg_rdata_o,
   .req_valid_i, .req_ready_o, .req_proto_i, .req_dev_addr_i, .resp_valid_o, .resp_proto_o,
   .us2_o, .sec_enable_o, .mb_addr_o, .mb_baud_o);
`default_nettype wire

/* File: host_model.sv */
// Host control system model that issues serial requests
`timescale 1ns/10ps
`default_nettype none
module host_model (
   // Clock
   input wire logic clk_i,
   // Request to the device
   output logic req_valid_o,
   output mos_pkg::proto_t req_proto_o,
   output logic [7:0] req_dev_addr_o,
   output mos_pkg::quantity_t req_qty_o,
   output logic req_has_mode_o,
   output mos_pkg::mode_t req_mode_o,
   // Answer from the device
   input wire logic req_ready_i,
   input wire logic resp_valid_i,
   input wire logic [15:0] resp_data_i
);
   // Idle request lines at time zero
   initial begin
      req_valid_o = 1'b0;
      req_proto_o = mos_pkg::PROTO_NATIVE;
      req_dev_addr_o = 8'h00;
      req_qty_o = mos_pkg::QTY_FILT_US;
      req_has_mode_o = 1'b0;
      req_mode_o = mos_pkg::MODE_F;
   end
   // request naming quantity, mode and address
   task automatic ask(input mos_pkg::proto_t p, input logic [7:0] a,
         input mos_pkg::quantity_t q, input logic hm, input mos_pkg::mode_t m,
         output logic hit, output logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      req_valid_o <= 1'b1;
      req_proto_o <= p;
      req_dev_addr_o <= a;
      req_qty_o <= q;
      req_has_mode_o <= hm;
      req_mode_o <= m;
      // Hold until ready is seen high, bounded
      do begin
         @(posedge clk_i);
         n++;
      end while (!req_ready_i && n < 20);
      // Released address, quantity and mode lines show the inverse, not the old value
      req_valid_o <= 1'b0;
      req_dev_addr_o <= ~a;
      req_qty_o <= mos_pkg::quantity_t'(~q);
      req_mode_o <= mos_pkg::mode_t'(~m);
      @(posedge clk_i);
      hit = resp_valid_i;
      d = resp_data_i;
   endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench for the measurement-mode output selector
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ce_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [2:0][15:0] filt_us_i = {16'h7000, 16'h2000, 16'h1000};
   logic [2:0][15:0] avg_us_i = {16'h0300, 16'h0200, 16'h0100};
   logic [15:0] reg_rdata_o, resp_data_o, aout1_o, aout2_o, us2_o;
   logic req_valid_i, req_ready_o, req_has_mode_i, resp_valid_o, sec_enable_o;
   logic [7:0] req_dev_addr_i, nat_addr_o, mb_addr_o;
   mos_pkg::proto_t req_proto_i, resp_proto_o;
   mos_pkg::quantity_t req_qty_i;
   mos_pkg::mode_t req_mode_i;
   mos_pkg::baud_t nat_baud_o, mb_baud_o;
   mos_pkg::parity_t mb_parity_o;
   int fail_count = 0;
   int check_count = 0;
   // Clock of 10 ns period
   always #5 clk_i = ~clk_i;
   mode_output_selector uut (.clk_i, .srst_i, .ce_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .filt_us_i, .avg_us_i, .req_valid_i, .req_ready_o,
      .req_proto_i, .req_dev_addr_i, .req_qty_i, .req_has_mode_i, .req_mode_i, .resp_valid_o,
      .resp_proto_o, .resp_data_o, .aout1_o, .aout2_o, .us2_o, .nat_addr_o, .nat_baud_o,
      .sec_enable_o, .mb_addr_o, .mb_baud_o, .mb_parity_o);
   host_model host (.clk_i, .req_valid_o(req_valid_i), .req_proto_o(req_proto_i),
      .req_dev_addr_o(req_dev_addr_i), .req_qty_o(req_qty_i), .req_has_mode_o(req_has_mode_i),
      .req_mode_o(req_mode_i), .req_ready_i(req_ready_o), .resp_valid_i(resp_valid_o),
      .resp_data_i(resp_data_o));
   // Compare and count
   task automatic chk(input string s, input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   // Register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   // Register read, data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(posedge clk_i);
      chk("register read", reg_rdata_o, e);
   endtask
   // Serial request through the host with expected answer
   task automatic ask(input mos_pkg::proto_t p, input logic [7:0] a,
         input mos_pkg::quantity_t q, input logic hm, input int m,
         input logic eh, input logic [15:0] e);
      logic hit;
      logic [15:0] d;
      host.ask(p, a, q, hm, mos_pkg::mode_t'(m), hit, d);
      chk("answered", {15'h0000, hit}, {15'h0000, eh});
      if (eh)
         chk("answer data", d, e);
   endtask
   // Verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #100000;
      fail_count++;
      results;
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(8'h04, 16'h0010);
      rd(8'h06, 16'h0001);
      rd(8'h07, 16'h0001);
      rd(8'h08, 16'h0003);
      rd(8'h09, 16'h0000);
      rd(8'h3f, 16'h0000);
      wr(8'h07, 16'h0000);
      wr(8'h07, 16'h00f8);
      rd(8'h07, 16'h0001);
      wr(8'h07, 16'h00f7);
      rd(8'h07, 16'h00f7);
      chk("native address", {8'h00, nat_addr_o}, 16'h0010);
      // A write while the clock enable is low is dropped
      ce_i <= 1'b0;
      wr(8'h04, 16'h0055);
      ce_i <= 1'b1;
      rd(8'h04, 16'h0010);
      // Every baud and parity code
      for (int i = 0; i < 8; i++) begin
         wr(8'h08, 16'(i));
         rd(8'h08, (i < 7) ? 16'(i) : 16'h0006);
         wr(8'h09, 16'(i % 4));
         rd(8'h09, 16'(i % 4));
      end
      chk("native baud", {13'h0000, nat_baud_o}, 16'h0003);
      // Each mode with both unscaled quantities named in the request
      for (int m = 0; m < 3; m++) begin
         ask(mos_pkg::PROTO_NATIVE, 8'h00, mos_pkg::QTY_FILT_US, 1'b1, m, 1'b1,
            (filt_us_i[m] > 16'h6400) ? 16'h6400 : filt_us_i[m]);
         ask(mos_pkg::PROTO_NATIVE, 8'h00, mos_pkg::QTY_AVG_US, 1'b1, m, 1'b1, avg_us_i[m]);
      end
      ask(mos_pkg::PROTO_NATIVE, 8'h00, mos_pkg::QTY_FILT_US, 1'b0, 2, 1'b1, 16'h1000);
      wr(8'h02, 16'h0002);
      ask(mos_pkg::PROTO_NATIVE, 8'h00, mos_pkg::QTY_FILT_US, 1'b0, 0, 1'b1, 16'h6400);
      wr(8'h02, 16'h0003);
      rd(8'h02, 16'h0000);
      wr(8'h02, 16'h0001);
      // Two loops on different modes, then one without a mode
      wr(8'h00, 16'h000d);
      wr(8'h01, 16'h0014);
      wr(8'h03, 16'h0002);
      repeat (4) @(posedge clk_i);
      chk("loop one", aout1_o, 16'h0200);
      chk("loop two", aout2_o, 16'h6400);
      chk("second unscaled", us2_o, 16'h6400);
      wr(8'h00, 16'h0000);
      repeat (4) @(posedge clk_i);
      chk("loop one fallback", aout1_o, 16'h2000);
      // Calibration sets: mode V linear, legacy cleared
      for (int i = 0; i < 16; i++)
         wr(8'h10 + 8'(i), 16'h0000);
      wr(8'h15, 16'h0100);
      wr(8'h16, 16'h0500);
      wr(8'h17, 16'h0100);
      rd(8'h15, 16'h0000);
      repeat (45) @(posedge clk_i);
      ask(mos_pkg::PROTO_NATIVE, 8'h00, mos_pkg::QTY_FILT_MOIST, 1'b1, 1, 1'b1, 16'h2400);
      rd(8'h22, 16'h2400);
      rd(8'h0a, 16'h0000);
      ask(mos_pkg::PROTO_NATIVE, 8'h00, mos_pkg::QTY_FILT_MOIST, 1'b0, 0, 1'b1, 16'h2400);
      wr(8'h1d, 16'h0200);
      rd(8'h0a, 16'h0002);
      repeat (45) @(posedge clk_i);
      ask(mos_pkg::PROTO_NATIVE, 8'h00, mos_pkg::QTY_FILT_MOIST, 1'b0, 0, 1'b1, 16'h4000);
      // Secondary protocol on the shared line
      ask(mos_pkg::PROTO_MODBUS, 8'hf7, mos_pkg::QTY_FILT_US, 1'b1, 0, 1'b1, 16'h1000);
      chk("answer protocol", {15'h0000, resp_proto_o}, 16'h0001);
      ask(mos_pkg::PROTO_MODBUS, 8'h01, mos_pkg::QTY_FILT_US, 1'b1, 0, 1'b0, 16'h0000);
      ask(mos_pkg::PROTO_MODBUS, 8'h00, mos_pkg::QTY_FILT_US, 1'b1, 0, 1'b0, 16'h0000);
      wr(8'h06, 16'h0000);
      ask(mos_pkg::PROTO_MODBUS, 8'hf7, mos_pkg::QTY_FILT_US, 1'b1, 0, 1'b0, 16'h0000);
      ask(mos_pkg::PROTO_NATIVE, 8'h00, mos_pkg::QTY_AVG_US, 1'b1, 2, 1'b1, 16'h0300);
      chk("answer protocol", {15'h0000, resp_proto_o}, 16'h0000);
      wr(8'h06, 16'h0001);
      ask(mos_pkg::PROTO_MODBUS, 8'hf7, mos_pkg::QTY_AVG_US, 1'b1, 1, 1'b1, 16'h0200);
      results;
   end
endmodule
`default_nettype wire
